// >>> dbs_pkg.sv
`default_nettype none

package dbs_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ADDR_W       = 6;
    localparam int WORD_W       = ADDR_W + 1;
    localparam int DEPTH        = 1 << WORD_W;
    localparam int LANES        = 4;
    localparam int LANE_W       = 9;
    localparam int DATA_W       = LANES * LANE_W;
    localparam int NARROW_W     = 18;
    localparam int BUF_DEPTH    = 2;
    localparam int CNT_W        = 2;

    // ------------------------------------------------------------
    // field values and reset values
    // ------------------------------------------------------------
    localparam logic       BEAT_FIRST   = 1'h0;
    localparam logic       BEAT_SECOND  = 1'h1;
    localparam logic [3:0] LANES_WIDE   = 4'hF;
    localparam logic [3:0] LANES_NARROW = 4'h3;
    localparam logic [3:0] LANES_NONE   = 4'h0;
    localparam logic [DATA_W-1:0] DQ_RST       = 36'h0_0000_0000;
    localparam logic [DATA_W-1:0] NARROW_MASK  = 36'h0_0003_FFFF;
    localparam logic [CNT_W-1:0]  BUF_FULL     = 2'h2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int LAT_PLL       = 2;
    localparam int LAT_LEGACY    = 1;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              vld;
        logic [ADDR_W-1:0] addr;
    } dbs_cmd_s;

    typedef struct packed {
        logic [WORD_W-1:0] word;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0]  we;
    } dbs_beat_s;

endpackage : dbs_pkg

`default_nettype wire

// >>> dbs_port.sv
// Function
// R01: a write is a low load with low read select at a K rise, data beats at the next K and K-bar rise.
// R02: a read is a low load with high read select at a K rise, data out at the K rise two cycles later, then K-bar.
// R03: after reset and on every K rise with load high the outputs float and nothing starts; the code keeps them driven if a read beat is due.
// R04: with both beat strobes stopped every output keeps its previous value; in the code wr_ready can still change as the write buffer drains.
// R05: the first beat uses the latched address, the second the next word of the burst.
// R06: write data is taken and read data launched on both K and K-bar rises.
// R07: in 18-bit mode two active-low selects write lanes [8:0] and [17:9], others unaltered.
// R08: in 36-bit mode four active-low selects each write one 9-bit lane, all high writes nothing.
// R09: byte selects are sampled separately on each beat and apply to that beat only.
// R10: the controller leaves at least two idle cycles between a read and a following write.
// R11: pending write data is returned to a read of the same word ahead of the array.
// R12: the valid flag rises half a cycle before read data and follows the data timing.
// R13: with the pll disable pin low the read latency is one cycle, otherwise two.
// R14: a new command may start on every K rise while earlier bursts complete.
`timescale 1ns/1ps
`default_nettype none

module dbs_port
(
    input  wire logic                        clk,
    input  wire logic                        rstn,
    input  wire logic                        k_rise,
    input  wire logic                        kbar_rise,
    input  wire logic                        cycle_load_n,
    input  wire logic                        read_write,
    input  wire logic [dbs_pkg::ADDR_W-1:0]  addr,
    input  wire logic [dbs_pkg::DATA_W-1:0]  dq_in,
    input  wire logic [dbs_pkg::LANES-1:0]   byte_lane_select_n,
    input  wire logic                        pll_disable_n,
    input  wire logic                        x18_mode,
    output logic      [dbs_pkg::DATA_W-1:0]  dq_out,
    output logic                             dq_oe_n,
    output logic                             read_valid_flag,
    output logic                             wr_ready
);

    // ------------------------------------------------------------
    // command pipeline
    // ------------------------------------------------------------
    dbs_pkg::dbs_cmd_s              rd0_ff, rd1_ff, wcap_ff;
    dbs_pkg::dbs_cmd_s              nxt_rd0, nxt_rd1, nxt_wcap;
    dbs_pkg::dbs_cmd_s              due;
    logic [dbs_pkg::ADDR_W-1:0]     cur_ff, nxt_cur, wb1a_ff, nxt_wb1a;
    logic                           b1_ff, nxt_b1, wb1_ff, nxt_wb1;
    logic                           launch0, launch1, launch, push0, push1;

    assign due     = pll_disable_n ? rd1_ff : rd0_ff;  // R13
    assign launch0 = k_rise & due.vld;                 // R02
    assign launch1 = kbar_rise & b1_ff;                // R06
    assign launch  = launch0 | launch1;
    assign push0   = k_rise & wcap_ff.vld;             // R01
    assign push1   = kbar_rise & wb1_ff;               // R06

    always_comb
    begin
        nxt_rd0  = rd0_ff;
        nxt_rd1  = rd1_ff;
        nxt_wcap = wcap_ff;
        nxt_cur  = cur_ff;
        nxt_b1   = b1_ff;
        nxt_wb1a = wb1a_ff;
        nxt_wb1  = wb1_ff;
        if (k_rise)
        begin
            nxt_rd0  = '{vld: ~cycle_load_n & read_write, addr: addr};   // R02 R03 R14
            nxt_rd1  = rd0_ff;
            nxt_wcap = '{vld: ~cycle_load_n & ~read_write, addr: addr};  // R01 R03 R14
            nxt_cur  = due.addr;
            nxt_b1   = due.vld;
            nxt_wb1a = wcap_ff.addr;
            nxt_wb1  = wcap_ff.vld;
        end
        else if (kbar_rise)
        begin
            nxt_b1  = 1'b0;
            nxt_wb1 = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd0_ff  <= '0;
            rd1_ff  <= '0;
            wcap_ff <= '0;
            cur_ff  <= '0;
            b1_ff   <= 1'b0;
            wb1a_ff <= '0;
            wb1_ff  <= 1'b0;
        end
        else
        begin
            rd0_ff  <= nxt_rd0;
            rd1_ff  <= nxt_rd1;
            wcap_ff <= nxt_wcap;
            cur_ff  <= nxt_cur;
            b1_ff   <= nxt_b1;
            wb1a_ff <= nxt_wb1a;
            wb1_ff  <= nxt_wb1;
        end
    end

    // ------------------------------------------------------------
    // write beat buffer
    // ------------------------------------------------------------
    dbs_pkg::dbs_beat_s             ent_ff [dbs_pkg::BUF_DEPTH];
    dbs_pkg::dbs_beat_s             nxt_ent [dbs_pkg::BUF_DEPTH];
    dbs_pkg::dbs_beat_s             in_beat, out_beat;
    logic                           wp_ff, nxt_wp, rp_ff, nxt_rp;
    logic [dbs_pkg::CNT_W-1:0]      cnt_ff, nxt_cnt;
    logic [dbs_pkg::LANES-1:0]      lane_mask;
    logic                           in_fire, out_fire;

    assign lane_mask     = x18_mode ? dbs_pkg::LANES_NARROW : dbs_pkg::LANES_WIDE;  // R07
    assign in_beat.word  = push0 ? {wcap_ff.addr, dbs_pkg::BEAT_FIRST}
                                 : {wb1a_ff, dbs_pkg::BEAT_SECOND};                 // R05
    assign in_beat.data  = dq_in;
    assign in_beat.we    = ~byte_lane_select_n & lane_mask;                         // R08 R09
    assign wr_ready      = cnt_ff != dbs_pkg::BUF_FULL;
    assign in_fire       = (push0 | push1) & wr_ready;
    assign out_fire      = (cnt_ff != '0) & ~launch;
    assign out_beat      = ent_ff[rp_ff];

    always_comb
    begin
        nxt_ent = ent_ff;
        nxt_wp  = wp_ff;
        nxt_rp  = rp_ff;
        nxt_cnt = cnt_ff;
        if (in_fire)
        begin
            nxt_ent[wp_ff] = in_beat;
            nxt_wp         = ~wp_ff;
        end
        if (out_fire)
        begin
            nxt_rp = ~rp_ff;
        end
        if (in_fire && !out_fire)
        begin
            nxt_cnt = cnt_ff + 2'h1;
        end
        else if (out_fire && !in_fire)
        begin
            nxt_cnt = cnt_ff - 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ent_ff <= '{default: '0};
            wp_ff  <= 1'b0;
            rp_ff  <= 1'b0;
            cnt_ff <= '0;
        end
        else
        begin
            ent_ff <= nxt_ent;
            wp_ff  <= nxt_wp;
            rp_ff  <= nxt_rp;
            cnt_ff <= nxt_cnt;
        end
    end

    // ------------------------------------------------------------
    // array with per-lane writes
    // ------------------------------------------------------------
    logic [dbs_pkg::WORD_W-1:0] rd_word;
    logic [dbs_pkg::DATA_W-1:0] arr_rd;

    for (genvar g = 0; g < dbs_pkg::LANES; g++)
    begin : g_lane
        logic [dbs_pkg::LANE_W-1:0] lane_mem [dbs_pkg::DEPTH];

        always_ff @(posedge clk)
        begin
            if (out_fire && out_beat.we[g])  // R07 R08
            begin
                lane_mem[out_beat.word] <= out_beat.data[g*dbs_pkg::LANE_W +: dbs_pkg::LANE_W];
            end
        end

        assign arr_rd[g*dbs_pkg::LANE_W +: dbs_pkg::LANE_W] = lane_mem[rd_word];
    end

    // ------------------------------------------------------------
    // read word with bypass of pending beats
    // ------------------------------------------------------------
    logic [dbs_pkg::DATA_W-1:0] rd_data;

    assign rd_word = launch0 ? {due.addr, dbs_pkg::BEAT_FIRST}
                             : {cur_ff, dbs_pkg::BEAT_SECOND};  // R05

    always_comb
    begin
        logic idx;
        idx     = 1'b0;
        rd_data = arr_rd;
        for (int i = 0; i < dbs_pkg::BUF_DEPTH; i++)
        begin
            idx = rp_ff ^ i[0];
            if ((cnt_ff > i[dbs_pkg::CNT_W-1:0]) && (ent_ff[idx].word == rd_word))  // R11
            begin
                for (int l = 0; l < dbs_pkg::LANES; l++)
                begin
                    if (ent_ff[idx].we[l])
                    begin
                        rd_data[l*dbs_pkg::LANE_W +: dbs_pkg::LANE_W] =
                            ent_ff[idx].data[l*dbs_pkg::LANE_W +: dbs_pkg::LANE_W];
                    end
                end
            end
        end
        if (x18_mode)
        begin
            rd_data = rd_data & dbs_pkg::NARROW_MASK;
        end
    end

    // ------------------------------------------------------------
    // output pins
    // ------------------------------------------------------------
    logic [dbs_pkg::DATA_W-1:0] dq_ff, nxt_dq;
    logic                       oe_n_ff, nxt_oe_n, vflag_ff, nxt_vflag;
    logic                       next_due;

    assign next_due = pll_disable_n ? rd1_ff.vld : rd0_ff.vld;

    always_comb
    begin
        nxt_dq    = dq_ff;
        nxt_oe_n  = oe_n_ff;
        nxt_vflag = vflag_ff;       // R04
        if (launch)
        begin
            nxt_dq   = rd_data;     // R02 R06
            nxt_oe_n = 1'b0;
        end
        else if (k_rise)
        begin
            nxt_oe_n = 1'b1;        // R03
        end
        if (kbar_rise)
        begin
            nxt_vflag = next_due;   // R12
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dq_ff    <= dbs_pkg::DQ_RST;
            oe_n_ff  <= 1'b1;       // R03
            vflag_ff <= 1'b0;
        end
        else
        begin
            dq_ff    <= nxt_dq;
            oe_n_ff  <= nxt_oe_n;
            vflag_ff <= nxt_vflag;
        end
    end

    assign dq_out          = dq_ff;
    assign dq_oe_n         = oe_n_ff;
    assign read_valid_flag = vflag_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic leg_arm_ff, nxt_leg_arm;

    always_comb
    begin
        nxt_leg_arm = leg_arm_ff;
        if (k_rise)
        begin
            nxt_leg_arm = !cycle_load_n && read_write && !pll_disable_n;  // R13
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            leg_arm_ff <= 1'b0;
        end
        else
        begin
            leg_arm_ff <= nxt_leg_arm;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_rd_cmd;
        k_rise && !cycle_load_n && read_write;
    endsequence

    sequence s_flag_arm;
        kbar_rise && next_due;
    endsequence

    sequence s_leg_due;
        k_rise && leg_arm_ff && !pll_disable_n;
    endsequence

    a_read_start: assert property (s_rd_cmd |=> rd0_ff.vld && rd0_ff.addr == $past(addr)) // R02
        else $error("read command not captured");
    a_read_lat: assert property (launch0 |=> !dq_oe_n && dq_out == $past(rd_data)) // R06
        else $error("read beat not launched");
    a_nop_hiz: assert property (k_rise && !due.vld && !launch1 |=> dq_oe_n) // R03
        else $error("outputs not floated on idle cycle");
    a_stop_hold: assert property (!k_rise && !kbar_rise |=> $stable(dq_out) && $stable(dq_oe_n)
                                   && $stable(read_valid_flag)) // R04
        else $error("outputs moved without a strobe");
    a_burst_addr: assert property (launch1 |-> rd_word == {cur_ff, dbs_pkg::BEAT_SECOND}) // R05
        else $error("second beat address wrong");
    a_write_beats: assert property (k_rise && wcap_ff.vld |=> wb1_ff && wb1a_ff == $past(wcap_ff.addr)) // R01
        else $error("second write beat not armed");
    a_narrow_lanes: assert property (x18_mode && in_fire |=>
                                     ent_ff[$past(wp_ff)].we[3:2] == 2'h0) // R07
        else $error("upper lanes written in narrow mode");
    a_beat_sel: assert property (in_fire |=>
                                 ent_ff[$past(wp_ff)].we == ($past(~byte_lane_select_n) & $past(lane_mask))) // R09
        else $error("byte selects not taken for this beat");
    a_valid_lead: assert property (s_flag_arm |=> read_valid_flag) // R12
        else $error("valid flag not set ahead of data");
    a_flag_ahead: assert property (launch0 |-> read_valid_flag) // R12
        else $error("first read beat launched without valid flag");
    a_legacy_lat: assert property (s_leg_due |-> launch0) // R13
        else $error("legacy latency missed");

endmodule : dbs_port

`default_nettype wire

// >>> dbs_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// controller model: K and K-bar edge strobes
// ------------------------------------------------------------
module dbs_ctrl_model
(
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic stop,
    input  wire logic slow,
    output logic      nxt_k,
    output logic      nxt_kb,
    output logic      k_rise,
    output logic      kbar_rise
);
    logic phase_ff;
    logic gap_ff;

    always_comb
    begin
        nxt_k  = !stop && !(slow && gap_ff) && !phase_ff;
        nxt_kb = !stop && !(slow && gap_ff) && phase_ff;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_ff  <= 1'b0;
            gap_ff    <= 1'b0;
            k_rise    <= 1'b0;
            kbar_rise <= 1'b0;
        end
        else
        begin
            k_rise    <= nxt_k;
            kbar_rise <= nxt_kb;
            gap_ff    <= nxt_k | nxt_kb;
            phase_ff  <= phase_ff ^ (nxt_k | nxt_kb);
        end
    end
endmodule : dbs_ctrl_model

`default_nettype wire

// >>> ddr_burst_sram_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module ddr_burst_sram_port_tb;
    typedef struct {int due; int w;} dbs_rd_s;
    logic clk, rstn, stop, slow, nxt_k, nxt_kb, k_rise, kbar_rise, k_d, kb_d, allsel;
    logic cycle_load_n, read_write, pll_disable_n, x18_mode, dq_oe_n, read_valid_flag, wr_ready;
    logic [dbs_pkg::ADDR_W-1:0] addr;
    logic [dbs_pkg::DATA_W-1:0] dq_in, dq_out, sd;
    logic [dbs_pkg::LANES-1:0]  byte_lane_select_n;
    logic [dbs_pkg::DATA_W-1:0] mem [dbs_pkg::DEPTH];
    logic [15:0]                rs = 16'h0003;
    dbs_rd_s                    rq[$];
    int num_errors = 0, checks = 0, kidx = 0, cyc = 0, rd_gap = 9, pw = 0, pa = 0, has1 = 0, w1;

    dbs_ctrl_model u_ctrl (.clk(clk), .rstn(rstn), .stop(stop), .slow(slow), .nxt_k(nxt_k),
        .nxt_kb(nxt_kb), .k_rise(k_rise), .kbar_rise(kbar_rise));
    dbs_port uut (.clk(clk), .rstn(rstn), .k_rise(k_rise), .kbar_rise(kbar_rise),
        .cycle_load_n(cycle_load_n), .read_write(read_write), .addr(addr), .dq_in(dq_in),
        .byte_lane_select_n(byte_lane_select_n), .pll_disable_n(pll_disable_n),
        .x18_mode(x18_mode), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .read_valid_flag(read_valid_flag), .wr_ready(wr_ready));

    initial
    begin
        clk = 1'b0;
        forever #(dbs_pkg::CLK_PERIOD_NS / 2) clk = ~clk;
    end

    function automatic logic [35:0] rnd();
        logic [47:0] v;
        repeat (3)
        begin
            rs = {rs[14:0], rs[15] ^ rs[13] ^ rs[12] ^ rs[10]};
            v = {v[31:0], rs};
        end
        return v[35:0];
    endfunction : rnd

    function automatic logic [35:0] rexp(input int w);
        return mem[w] & (x18_mode ? dbs_pkg::NARROW_MASK : {dbs_pkg::DATA_W{1'b1}});
    endfunction : rexp

    task automatic edge_drv(input logic kb);
        int n;
        logic [35:0] d;
        logic [3:0] s;
        n = 0;
        do begin @(posedge clk); n++; end while ((kb ? nxt_kb : nxt_k) !== 1'b1 && n < 40);
        d = rnd();
        s = allsel ? 4'h0 : d[35:32];
        dq_in <= d;
        byte_lane_select_n <= s;
        if (pw)
            for (int i = 0; i < 4; i++)
                if (!s[i] && (!x18_mode || i < 2))
                    mem[pa * 2 + kb][i * 9 +: 9] = d[i * 9 +: 9];
    endtask : edge_drv

    task automatic kcyc(input logic ld_n, input logic rw, input logic [5:0] a);
        edge_drv(1'b0);
        cycle_load_n <= ld_n;
        read_write <= rw;
        addr <= a;
        if (!ld_n && rw) rq.push_back('{kidx + (pll_disable_n ? 3 : 2), int'(a) * 2});
        edge_drv(1'b1);
        cycle_load_n <= 1'b1;
        pw = !ld_n && !rw;
        pa = a;
        rd_gap = (!ld_n && rw) ? 0 : rd_gap + 1;
    endtask : kcyc

    task automatic op(input logic rw, input logic [5:0] a);
        while (!rw && rd_gap < 2) kcyc(1'b1, 1'b0, 6'h00);
        kcyc(1'b0, rw, a);
    endtask : op

    task automatic summarize();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // strobe tracking, timeout
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        k_d <= k_rise;
        kb_d <= kbar_rise;
        if (k_rise) kidx <= kidx + 1;
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            summarize();
        end
    end

    // ------------------------------------------------------------
    // read data monitor
    // ------------------------------------------------------------
    always @(negedge clk)
    if (rstn)
    begin
        if (k_d)
        begin
            if (rq.size() != 0 && rq[0].due == kidx)
            begin
                `CHK("rd_beat0", rexp(rq[0].w), dq_out)
                `CHK("oe_read", 1'b0, dq_oe_n)
                w1 = rq[0].w + 1;
                has1 = 1;
                void'(rq.pop_front());
            end
            else `CHK("oe_idle", 1'b1, dq_oe_n)
        end
        if (kb_d)
        begin
            if (has1) `CHK("rd_beat1", rexp(w1), dq_out)
            has1 = 0;
            `CHK("valid_flag", (rq.size() != 0 && rq[0].due == kidx + 1), read_valid_flag)
        end
    end

    initial
    begin
        rstn = 1'b0; stop = 1'b0; slow = 1'b0; allsel = 1'b1; k_d = 1'b0; kb_d = 1'b0;
        cycle_load_n = 1'b1; read_write = 1'b0; addr = '0; dq_in = '0;
        byte_lane_select_n = 4'hF; pll_disable_n = 1'b1; x18_mode = 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        `CHK("oe_rst", 1'b1, dq_oe_n)
        `CHK("dq_rst", dbs_pkg::DQ_RST, dq_out)
        `CHK("vld_rst", 1'b0, read_valid_flag)
        `CHK("rdy_rst", 1'b1, wr_ready)
        $display("test reset done");
        for (int i = 0; i < 8; i++) op(1'b0, i[5:0]);
        for (int i = 0; i < 8; i++) op(1'b1, i[5:0]);
        allsel = 1'b0;
        $display("test fill done");
        for (int m = 0; m < 4; m++)
        begin
            repeat (5) kcyc(1'b1, 1'b0, 6'h00);
            pll_disable_n <= (m != 1);
            x18_mode <= (m == 2);
            slow <= (m == 3);
            for (int i = 0; i < 24; i++)
            begin
                logic [35:0] r;
                r = rnd();
                op(r[0], {3'h0, r[3:1]});
            end
            $display("test mode %0d done", m);
        end
        repeat (5) kcyc(1'b1, 1'b0, 6'h00);
        slow <= 1'b0;
        op(1'b1, 6'h05);
        kcyc(1'b1, 1'b0, 6'h00);
        stop <= 1'b1;
        repeat (3) @(negedge clk);
        sd = dq_out;
        repeat (8) @(negedge clk);
        `CHK("stop_dq", sd, dq_out)
        `CHK("stop_vld", 1'b1, read_valid_flag)
        `CHK("stop_oe", 1'b1, dq_oe_n)
        stop <= 1'b0;
        repeat (5) kcyc(1'b1, 1'b0, 6'h00);
        $display("test clock stop done");
        summarize();
    end
endmodule : ddr_burst_sram_port_tb

`default_nettype wire
